// ===== hw/wake_agg_regs.vh
`ifndef WAKE_AGG_REGS_VH
`define WAKE_AGG_REGS_VH

// group count and width
`define NUM_GROUPS      16
`define GROUP_WIDTH     32
`define GROUP_EIGHT     8
`define GROUP_NINE      9
`define GROUP_EIGHT_W   22
`define GROUP_NINE_W    31
// aggregated vectors at the processor
`define VEC_GROUP_EIGHT 57
`define VEC_GROUP_NINE  58

// per group register slots, addr[3:2]
`define REG_STATUS      2'h0
`define REG_EN_SET      2'h1
`define REG_EN_CLR      2'h2
`define REG_RESULT      2'h3
// global registers, addr[8] set
`define REG_GROUP_SEL   9'h100
`define REG_CONTROL     9'h104
`define REG_WAKE_STAT   9'h108
`define CTRL_ROUTE_BIT  0

// reset values
`define RST_STATUS      32'h0
`define RST_ENABLE      32'h0
`define RST_GROUP_SEL   16'h0
`define RST_ROUTE       1'b0

// pin edge detection codes
`define DET_W           3
`define DET_RISE        3'h5
`define DET_FALL        3'h6
`define DET_EITHER      3'h7

`endif

// ===== hw/wake_interrupt_aggregator.v
// Behaviour
// - any enabled wake-capable event raises the wake request toward power management.
// - the wake request path is combinational, working with no clock running.
// - wake is the OR over wake-capable sources of each source ANDed with its enable.
// - a pin input can wake only while its detection setting is rising, falling or either edge.
// - a shared-pin wake source wakes only while its pin's detection setting is an edge mode.
// - debug accesses are no wake source; firmware arms a falling edge on the debug clock pin.
// - group eight holds pins 140 to 165 at bits 0 to 21, all wake-capable, vector 57.
// - group nine holds pins 100 to 136 at bits 0 to 30, all wake-capable, vector 58.
// - result is status AND enable, and the OR of result gated by group select drives the group line.
// - there are sixteen groups, each with latched status and enable and a derived result.
// - with direct routing enabled every result bit is also forwarded on its own line.
`timescale 1ns/100ps
`default_nettype none
`include "wake_agg_regs.vh"

module wake_interrupt_aggregator
#(
  parameter [511:0] OTHER_WAKE_MASK = 512'h0,
  parameter [511:0] SHARED_PIN_MASK = 512'h0
)
(
  input  wire         clk_sys,
  input  wire         rst,
  input  wire [8:0]   addr,
  input  wire [31:0]  wr_data,
  input  wire         wr_en,
  input  wire         rd_en,
  output reg  [31:0]  rd_data,
  input  wire [511:0] src_event,
  input  wire [21:0]  pin_event_g8,
  input  wire [65:0]  det_mode_g8,
  input  wire [30:0]  pin_event_g9,
  input  wire [92:0]  det_mode_g9,
  input  wire [511:0] shared_edge_ok,
  output reg  [15:0]  group_irq,
  output reg  [511:0] direct_irq,
  output wire         wake_request
);

  ////////////////////////////////////////////////////////////////////////////
  // storage

  reg  [31:0]  stat [0:15];
  reg  [31:0]  en   [0:15];
  reg  [15:0]  group_sel;
  reg          route_en;
  wire [511:0] src_all;
  wire [511:0] stat_flat;
  wire [511:0] en_flat;
  wire [511:0] result_flat;
  wire [511:0] wake_ok;
  wire [511:0] wake_vec;
  wire [21:0]  qual_g8;
  wire [30:0]  qual_g9;
  wire         wr_grp;
  wire [3:0]   wr_g;
  wire [1:0]   wr_r;
  reg  [31:0]  next_rd;
  integer      g;
  integer      k;

  assign wr_grp = wr_en & ~addr[8];
  assign wr_g   = addr[7:4];
  assign wr_r   = addr[3:2];

  ////////////////////////////////////////////////////////////////////////////
  // pin qualifiers from edge detection setting

  genvar i;
  generate
    for (i = 0; i < `GROUP_EIGHT_W; i = i + 1)
    begin : q8
      assign qual_g8[i] = (det_mode_g8[i*3 +: 3] == `DET_RISE) |
                          (det_mode_g8[i*3 +: 3] == `DET_FALL) |
                          (det_mode_g8[i*3 +: 3] == `DET_EITHER);
    end
    for (i = 0; i < `GROUP_NINE_W; i = i + 1)
    begin : q9
      assign qual_g9[i] = (det_mode_g9[i*3 +: 3] == `DET_RISE) |
                          (det_mode_g9[i*3 +: 3] == `DET_FALL) |
                          (det_mode_g9[i*3 +: 3] == `DET_EITHER);
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // source mapping, flattening and wake qualification per group

  generate
    for (i = 0; i < `NUM_GROUPS; i = i + 1)
    begin : grp
      if (i == `GROUP_EIGHT)
      begin : ge
        // pins 140..165 at bits 0..21
        assign src_all[i*32 +: 32] = {10'h0, pin_event_g8};
        assign wake_ok[i*32 +: 32] = {10'h0, qual_g8};
      end
      else if (i == `GROUP_NINE)
      begin : gn
        // pins 100..136 at bits 0..30
        assign src_all[i*32 +: 32] = {1'b0, pin_event_g9};
        assign wake_ok[i*32 +: 32] = {1'b0, qual_g9};
      end
      else
      begin : go
        assign src_all[i*32 +: 32] = src_event[i*32 +: 32];
        // shared-pin sources need an edge mode on their pin
        assign wake_ok[i*32 +: 32] = OTHER_WAKE_MASK[i*32 +: 32] &
          (~SHARED_PIN_MASK[i*32 +: 32] | shared_edge_ok[i*32 +: 32]);
      end
      assign stat_flat[i*32 +: 32]   = stat[i];
      assign en_flat[i*32 +: 32]     = en[i];
      assign result_flat[i*32 +: 32] = stat[i] & en[i];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // wake request, no clock in the path; raw events cover clock-off sleep,
  // latched status holds the request until cleared or disabled.
  // debug port activity has no input here and cannot wake.

  assign wake_vec     = (src_all | stat_flat) & en_flat & wake_ok;
  assign wake_request = |wake_vec;

  ////////////////////////////////////////////////////////////////////////////
  // status and enable registers for all sixteen groups

  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      for (g = 0; g < `NUM_GROUPS; g = g + 1)
      begin
        stat[g] <= `RST_STATUS;
        en[g]   <= `RST_ENABLE;
      end
    end
    else
    begin
      for (g = 0; g < `NUM_GROUPS; g = g + 1)
      begin
        // write one clears, a new event wins over the clear
        stat[g] <= (stat[g] & ~((wr_grp && wr_g == g[3:0] && wr_r == `REG_STATUS) ?
                   wr_data : 32'h0)) | src_all[g*32 +: 32];
        if (wr_grp && wr_g == g[3:0] && wr_r == `REG_EN_SET)
          en[g] <= en[g] | wr_data;
        else if (wr_grp && wr_g == g[3:0] && wr_r == `REG_EN_CLR)
          en[g] <= en[g] & ~wr_data;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // global control registers

  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      group_sel <= `RST_GROUP_SEL;
      route_en  <= `RST_ROUTE;
    end
    else if (wr_en && addr == `REG_GROUP_SEL)
      group_sel <= wr_data[15:0];
    else if (wr_en && addr == `REG_CONTROL)
      route_en  <= wr_data[`CTRL_ROUTE_BIT];
  end

  ////////////////////////////////////////////////////////////////////////////
  // aggregated and direct interrupt lines

  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      group_irq  <= 16'h0;
      direct_irq <= 512'h0;
    end
    else
    begin
      for (k = 0; k < `NUM_GROUPS; k = k + 1)
        group_irq[k] <= (|result_flat[k*32 +: 32]) & group_sel[k];
      direct_irq <= route_en ? result_flat : 512'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read decode

  always @*
  begin
    next_rd = 32'h0;
    if (addr[8])
    begin
      case (addr)
        `REG_GROUP_SEL: next_rd = {16'h0, group_sel};
        `REG_CONTROL:   next_rd = {31'h0, route_en};
        `REG_WAKE_STAT: next_rd = {31'h0, wake_request};
        default:        next_rd = 32'h0;
      endcase
    end
    else
    begin
      case (wr_r)
        `REG_STATUS: next_rd = stat[addr[7:4]];
        `REG_EN_SET: next_rd = en[addr[7:4]];
        `REG_EN_CLR: next_rd = en[addr[7:4]];
        `REG_RESULT: next_rd = stat[addr[7:4]] & en[addr[7:4]];
        default:     next_rd = 32'h0;
      endcase
    end
  end

  // read data one cycle after strobe, held otherwise
  always @(posedge clk_sys)
  begin
    if (rst)
      rd_data <= 32'h0;
    else if (rd_en)
      rd_data <= next_rd;
  end

endmodule

`default_nettype wire

// ===== tb/wake_agg_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module wake_agg_asserts (
  input wire         clk_sys,
  input wire         rst,
  input wire [8:0]   addr,
  input wire [31:0]  wr_data,
  input wire         wr_en,
  input wire         rd_en,
  input wire [31:0]  rd_data,
  input wire [15:0]  group_irq,
  input wire [511:0] direct_irq,
  input wire         wake_request
);
  logic [15:0] sel_q;
  logic        route_q;
  // shadows of group select and route enable
  always @(posedge clk_sys)
  begin
    sel_q <= rst ? 16'h0 : wr_en && addr == 9'h100 ? wr_data[15:0] : sel_q;
    route_q <= rst ? 1'b0 : wr_en && addr == 9'h104 ? wr_data[0] : route_q;
  end
  default clocking @(posedge clk_sys); endclocking
  reset_read_a: assert property (rst |=> rd_data == 32'h0)
    else $error("read data after reset");
  reset_irq_a: assert property (rst |=> !group_irq && !direct_irq)
    else $error("irq after reset");
  wake_reset_a: assert property ($past(rst) |-> !wake_request)
    else $error("wake with enables clear");
  unmapped_read_a: assert property (disable iff (rst)
    rd_en && addr == 9'h1fc |=> rd_data == 32'h0) else $error("unmapped read");
  read_hold_a: assert property (disable iff (rst)
    !$past(rd_en) |-> $stable(rd_data)) else $error("read data moved");
  sel_read_a: assert property (disable iff (rst)
    rd_en && addr == 9'h100 |=> rd_data == {16'h0, sel_q}) else $error("select read");
  group_gate_a: assert property (disable iff (rst)
    (sel_q == 16'h0)[*2] |-> !group_irq) else $error("group line ungated");
  route_gate_a: assert property (disable iff (rst)
    (!route_q)[*2] |-> !direct_irq) else $error("direct line ungated");
endmodule
bind wake_interrupt_aggregator wake_agg_asserts u_chk (.clk_sys, .rst, .addr, .wr_data,
  .wr_en, .rd_en, .rd_data, .group_irq, .direct_irq, .wake_request);
`default_nettype wire

// ===== tb/pm_model.sv
`timescale 1ns/100ps
`default_nettype none
module pm_model (
  input  wire logic [15:0] group_irq,
  input  wire logic        wake_request,
  output var  logic [63:0] vec_pend,
  output var  int          wake_cnt
);
  // group eight and nine lines land on vectors 57 and 58
  assign vec_pend = {5'h0, group_irq[9:8], 57'h0};
  // wake counted on its edge, no clock used
  initial wake_cnt = 0;
  always @(posedge wake_request) wake_cnt++;
endmodule
`default_nettype wire

// ===== tb/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic clk_sys = 1'b0, rst = 1'b1, wr_en = 1'b0, rd_en = 1'b0, wake_request;
  logic [8:0] addr = 9'h0;
  logic [31:0] wr_data = 32'h0, rd_data;
  logic [511:0] src_event = 512'h0, shared_edge_ok = 512'h0, direct_irq;
  logic [21:0] pin_event_g8 = 22'h0;
  logic [65:0] det_mode_g8 = 66'h0;
  logic [30:0] pin_event_g9 = 31'h0;
  logic [92:0] det_mode_g9 = 93'h0;
  logic [15:0] group_irq;
  logic [63:0] vec_pend;
  int wake_cnt, error_cnt = 0, cmp_count = 0;
  always #2.5 clk_sys = ~clk_sys;
  // group ten bits 0 and 1 wake-capable, bit 1 sits on a shared pin
  wake_interrupt_aggregator #(.OTHER_WAKE_MASK(512'h3 << 320),
    .SHARED_PIN_MASK(512'h2 << 320))
    dut (.clk_sys, .rst, .addr, .wr_data, .wr_en, .rd_en, .rd_data,
    .src_event, .pin_event_g8, .det_mode_g8, .pin_event_g9, .det_mode_g9, .shared_edge_ok,
    .group_irq, .direct_irq, .wake_request);
  pm_model pm (.group_irq, .wake_request, .vec_pend, .wake_cnt);
  task automatic close_out();
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] g, e);
    cmp_count++;
    if (g !== e)
    begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  // one strobe cycle; a read is compared in the cycle after it
  task automatic bus(input logic w, input logic [8:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    wr_en <= w;
    rd_en <= !w;
    addr <= a;
    wr_data <= d;
    @(posedge clk_sys);
    wr_en <= 1'b0;
    rd_en <= 1'b0;
    #1 if (!w) cmp(rd_data, d);
  endtask
  // bounded wait on a processor vector
  task automatic wait_vec(input int v, input logic e);
    int i;
    for (i = 0; i < 20 && vec_pend[v] !== e; i++)
      #5;
    if (i == 20)
    begin
      error_cnt++;
      close_out();
    end
    cmp(vec_pend[v], e);
  endtask
  // main sequence
  initial
  begin
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    bus(1'b0, 9'h1fc, 32'h0);
    bus(1'b1, 9'h84, 32'h1);
    bus(1'b0, 9'h88, 32'h1);
    bus(1'b1, 9'h100, 32'h300);
    bus(1'b0, 9'h100, 32'h300);
    for (int m = 0; m < 8; m++)
    begin
      @(posedge clk_sys);
      det_mode_g8[2:0] <= m[2:0];
      pin_event_g8[0] <= 1'b1;
      #1 cmp(wake_request, m > 4);
      @(posedge clk_sys);
      pin_event_g8[0] <= 1'b0;
    end
    wait_vec(57, 1'b1);
    bus(1'b0, 9'h8c, 32'h1);
    bus(1'b1, 9'h104, 32'h1);
    #5 cmp(direct_irq[256], 1'b1);
    bus(1'b1, 9'h80, 32'h1);
    cmp(wake_request, 1'b0);
    wait_vec(57, 1'b0);
    $display("test group eight done");
    bus(1'b1, 9'h94, 32'h40000000);
    @(posedge clk_sys);
    det_mode_g9[92:90] <= 3'h6;
    pin_event_g9[30] <= 1'b1;
    #1 cmp(wake_request, 1'b1);
    wait_vec(58, 1'b1);
    bus(1'b1, 9'h98, 32'h40000000);
    cmp(wake_request, 1'b0);
    wait_vec(58, 1'b0);
    cmp(wake_cnt, 32'h2);
    $display("test group nine done");
    // shared-pin source wakes only with its pin in an edge mode
    bus(1'b1, 9'ha4, 32'h3);
    @(posedge clk_sys);
    src_event[321] <= 1'b1;
    #1 cmp(wake_request, 1'b0);
    @(posedge clk_sys);
    shared_edge_ok[321] <= 1'b1;
    #1 cmp(wake_request, 1'b1);
    bus(1'b0, 9'h108, 32'h1);
    bus(1'b1, 9'ha0, 32'h2);
    bus(1'b0, 9'ha0, 32'h2);
    cmp(direct_irq[321], 1'b1);
    bus(1'b1, 9'ha8, 32'h3);
    cmp(wake_request, 1'b0);
    bus(1'b0, 9'h104, 32'h1);
    cmp(direct_irq[321], 1'b0);
    cmp(wake_cnt, 32'h3);
    $display("test shared pin done");
    close_out();
  end
endmodule
`default_nettype wire
